// ===== src/fbsi_map.vh
`ifndef FBSI_MAP_VH
`define FBSI_MAP_VH
// network states
`define FBSI_NET_INIT      3'h0
`define FBSI_NET_PREOP     3'h1
`define FBSI_NET_OPER      3'h2
`define FBSI_NET_STOP      3'h3
`define FBSI_NET_BAUDSCAN  3'h4
// lamp patterns
`define FBSI_PAT_OFF       3'h0
`define FBSI_PAT_ON        3'h1
`define FBSI_PAT_BLINK     3'h2
`define FBSI_PAT_SINGLE    3'h3
`define FBSI_PAT_DOUBLE    3'h4
`define FBSI_PAT_FLICKER   3'h5
// timing: flicker 50 ms period, slot 200 ms; times in ms
`define FBSI_FLICK_MS      25
`define FBSI_SLOT_MS       200
`define FBSI_CYC_PER_MS    100000
// wide enough for the longest reload value, the 200 ms slot
`define FBSI_DIV_W         25
`define FBSI_SLOT_W        3
`define FBSI_SLOT_LAST     3'h7
`define FBSI_SLOT_FLASH_A  3'h0
`define FBSI_SLOT_FLASH_B  3'h2
// settings
`define FBSI_ADDR_W        7
`define FBSI_ADDR_MAX      7'h7e
`define FBSI_ADDR_UNSET    7'h00
`define FBSI_RATE_W        4
`define FBSI_RATE_MAX      4'h8
`define FBSI_RATE_AUTO     4'h0
`endif

// ===== src/fbsi_pattern.v
`timescale 1ns/1ps
`default_nettype none
`include "fbsi_map.vh"
// turns a pattern code plus shared phase into a lamp level
module fbsi_pattern (
    input  wire                     sys_clk,
    input  wire                     sys_rst,
    input  wire [2:0]               pattern,
    input  wire [`FBSI_SLOT_W-1:0]  slot,
    input  wire                     flick_ph,
    input  wire                     invert,
    output reg                      lamp_q
);
    reg lamp_d; // next lamp level
    // slot 0..7 of 200 ms: single = lit slot 0, double = slots 0 and 2
    always @* begin
        case (pattern)
            `FBSI_PAT_ON:      lamp_d = 1'b1;
            `FBSI_PAT_BLINK:   lamp_d = ~slot[0];
            `FBSI_PAT_SINGLE:  lamp_d = (slot == `FBSI_SLOT_FLASH_A);
            `FBSI_PAT_DOUBLE:  lamp_d = (slot == `FBSI_SLOT_FLASH_A) |
                                        (slot == `FBSI_SLOT_FLASH_B);
            `FBSI_PAT_FLICKER: lamp_d = flick_ph ^ invert;
            default:           lamp_d = 1'b0;
        endcase
    end
    // registered so the lamp never glitches
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lamp_q <= 1'b0;
        end else begin
            lamp_q <= lamp_d;
        end
    end
endmodule // fbsi_pattern
`default_nettype wire

// ===== src/fbsi_top.v
`timescale 1ns/1ps
`default_nettype none
`include "fbsi_map.vh"
// Overview of operation
// - drive green run and red error lamps
// - run: on oper, blink preop, flash stopped
// - error: on bus-off, blink init failure
// - error single flash: fault or error frames
// - error double flash on guard/heartbeat event
// - baud detection flickers run lamp
// - error lamp flickers opposite run lamp
// - address zero at power-up raises alarm
// - settings latched only at power-up
// - address 0..126, rate code 0..8
module fbsi_top (
    input  wire                     sys_clk,
    input  wire                     sys_rst,
    // status levels from the protocol stack, sampled every edge
    input  wire [2:0]               net_state,
    input  wire                     bus_off,
    input  wire                     init_failed,
    input  wire                     fault_active,
    input  wire                     error_frames,
    input  wire                     guard_event,
    // drive settings, read once after each reset
    input  wire [`FBSI_ADDR_W-1:0]  node_address_setting,
    input  wire [`FBSI_RATE_W-1:0]  bit_rate_setting,
    // lamp levels, high means lit
    output wire                     run_lamp,
    output wire                     err_lamp,
    // alarm and captured settings, fixed until the next reset
    output wire                     address_unset_alarm,
    output wire                     join_enable,
    output wire [`FBSI_ADDR_W-1:0]  active_address,
    output wire [`FBSI_RATE_W-1:0]  active_rate,
    output wire                     auto_rate
);
    // all lamp timing comes from the two counters below; the flicker
    // and slot lengths live in the map header, and a smaller cycles
    // per ms there makes the slow patterns visible in a short run
    // counts worked out as integers, then cut to the counter width;
    // counters reload at these values, one cycle below the length
    localparam integer FLICK_INT = `FBSI_FLICK_MS * `FBSI_CYC_PER_MS - 1;
    localparam integer SLOT_INT  = `FBSI_SLOT_MS * `FBSI_CYC_PER_MS - 1;
    localparam [`FBSI_DIV_W-1:0]  FLICK_CYC = FLICK_INT[`FBSI_DIV_W-1:0];
    localparam [`FBSI_DIV_W-1:0]  SLOT_CYC  = SLOT_INT[`FBSI_DIV_W-1:0];
    localparam [`FBSI_DIV_W-1:0]  DIV_ONE   = {{(`FBSI_DIV_W-1){1'b0}}, 1'b1};
    localparam [`FBSI_SLOT_W-1:0] SLOT_ONE  = {{(`FBSI_SLOT_W-1){1'b0}}, 1'b1};

    reg [`FBSI_DIV_W-1:0]  flick_cnt_q; // flicker half period
    reg                    flick_ph_q;  // flicker phase
    reg [`FBSI_DIV_W-1:0]  slot_cnt_q;  // slot timer
    reg [`FBSI_SLOT_W-1:0] slot_q;      // slot index in 1.6 s frame
    reg                    latched_q;   // settings taken once
    reg [2:0]              run_pat;     // chosen run pattern
    reg [2:0]              err_pat;     // chosen error pattern
    wire                   scanning;    // baud detection in progress

    // captured settings and their next values
    reg                    latched_d;   // capture done after this edge
    reg [`FBSI_ADDR_W-1:0] addr_q;      // captured node address
    reg [`FBSI_ADDR_W-1:0] addr_d;
    reg [`FBSI_RATE_W-1:0] rate_q;      // captured rate code
    reg [`FBSI_RATE_W-1:0] rate_d;
    reg                    auto_q;      // captured rate was automatic
    reg                    auto_d;
    reg                    alarm_q;     // address was unset at power-up
    reg                    alarm_d;
    reg                    join_q;      // node may join the network
    reg                    join_d;

    // scan overrides both lamps; this decode feeds the error lamp, the run case decodes it again
    assign scanning = (net_state == `FBSI_NET_BAUDSCAN);

    // flicker timebase, free running; both lamps share this one
    // phase, so their alternation can never drift apart
    // no restart on entering scan: the first half period may be short
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flick_cnt_q <= {`FBSI_DIV_W{1'b0}};
            flick_ph_q  <= 1'b0;
        end else if (flick_cnt_q == FLICK_CYC) begin
            flick_cnt_q <= {`FBSI_DIV_W{1'b0}};
            flick_ph_q  <= ~flick_ph_q;
        end else begin
            flick_cnt_q <= flick_cnt_q + DIV_ONE;
        end
    end

    // slot timebase shared by blink and flashes, so lamps stay aligned
    // the slot index wraps by itself after the last slot of the frame
    // a pattern change mid-frame joins the running frame, no restart
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_cnt_q <= {`FBSI_DIV_W{1'b0}};
            slot_q     <= {`FBSI_SLOT_W{1'b0}};
        end else if (slot_cnt_q == SLOT_CYC) begin
            slot_cnt_q <= {`FBSI_DIV_W{1'b0}};
            slot_q     <= slot_q + SLOT_ONE;
        end else begin
            slot_cnt_q <= slot_cnt_q + DIV_ONE;
        end
    end

    // run lamp selection
    // pure decode of the network state; no error cause touches it
    always @* begin
        case (net_state)
            `FBSI_NET_OPER:     run_pat = `FBSI_PAT_ON;
            `FBSI_NET_PREOP:    run_pat = `FBSI_PAT_BLINK;
            `FBSI_NET_STOP:     run_pat = `FBSI_PAT_SINGLE;
            `FBSI_NET_BAUDSCAN: run_pat = `FBSI_PAT_FLICKER;
            // init and undefined codes keep the run lamp dark
            default:            run_pat = `FBSI_PAT_OFF;
        endcase
    end

    // error lamp selection, most severe first
    // scan sits on top so the alternation is never broken by a cause
    always @* begin
        if (scanning) begin
            err_pat = `FBSI_PAT_FLICKER;
        end else if (bus_off) begin
            err_pat = `FBSI_PAT_ON;
        end else if (init_failed) begin
            // a setting error keeps the node off the bus
            err_pat = `FBSI_PAT_BLINK;
        end else if (guard_event) begin
            // guard ranks above single flash: a lost peer matters more
            err_pat = `FBSI_PAT_DOUBLE;
        end else if (fault_active | error_frames) begin
            err_pat = `FBSI_PAT_SINGLE;
        end else begin
            err_pat = `FBSI_PAT_OFF;
        end
    end

    // one pattern engine per lamp
    // both read the same slot and phase, so patterns stay in step
    fbsi_pattern u_run (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pattern  (run_pat),
        .slot     (slot_q),
        .flick_ph (flick_ph_q),
        .invert   (1'b0),
        .lamp_q   (run_lamp)
    );
    // inverted phase keeps the two lamps never lit together while both flicker in scan
    // the lamp registers share a clock, so both switch on one edge
    fbsi_pattern u_err (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .pattern  (err_pat),
        .slot     (slot_q),
        .flick_ph (flick_ph_q),
        .invert   (1'b1),
        .lamp_q   (err_lamp)
    );

    // next values of the captured settings; they differ from the
    // present ones only in the single capture cycle after reset
    always @* begin
        // hold everything unless the capture is still open
        latched_d = latched_q;
        addr_d    = addr_q;
        rate_d    = rate_q;
        auto_d    = auto_q;
        alarm_d   = alarm_q;
        join_d    = join_q;
        if (!latched_q) begin
            latched_d = 1'b1;
            // out-of-range values are clamped to the top legal code,
            // so a stray setting never picks an undefined node or rate
            if (node_address_setting > `FBSI_ADDR_MAX) begin
                addr_d = `FBSI_ADDR_MAX;
            end else begin
                addr_d = node_address_setting;
            end
            if (bit_rate_setting > `FBSI_RATE_MAX) begin
                rate_d = `FBSI_RATE_MAX;
            end else begin
                rate_d = bit_rate_setting;
            end
            // code zero asks the stack to detect the rate itself
            auto_d  = (bit_rate_setting == `FBSI_RATE_AUTO);
            // unset address: alarm instead of joining
            alarm_d = (node_address_setting == `FBSI_ADDR_UNSET);
            join_d  = (node_address_setting != `FBSI_ADDR_UNSET);
        end
    end

    // capture flops; only a reset, which stands for power-up, reopens
    // the capture, so edits made while running stay inactive until then
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // nothing captured, no alarm, not joined
            latched_q <= 1'b0;
            addr_q    <= {`FBSI_ADDR_W{1'b0}};
            rate_q    <= {`FBSI_RATE_W{1'b0}};
            auto_q    <= 1'b0;
            alarm_q   <= 1'b0;
            join_q    <= 1'b0;
        end else begin
            latched_q <= latched_d;
            addr_q    <= addr_d;
            rate_q    <= rate_d;
            auto_q    <= auto_d;
            alarm_q   <= alarm_d;
            join_q    <= join_d;
        end
    end

    // outputs come straight from the capture flops; join stays low while
    // the alarm is up, so the stack never goes online at address zero
    assign address_unset_alarm = alarm_q;
    assign join_enable         = join_q;
    assign active_address      = addr_q;
    assign active_rate         = rate_q;
    assign auto_rate           = auto_q;
endmodule // fbsi_top
`default_nettype wire

// ===== tb/fbsi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side master: moves node state, raises bus events
module fbsi_master_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] cmd,
    output var  logic [2:0] net_state = 3'h0,
    output var  logic [4:0] events    = 5'h00
);
    // a command lands one edge late, as over a real bus
    always @(posedge sys_clk) begin
        net_state <= cmd[7:5];
        events    <= cmd[4:0];
    end
endmodule // fbsi_master_model
`default_nettype wire

// ===== tb/fbsi_props.sv
`timescale 1ns/1ps
`default_nettype none
// lamp and latched-setting relations at the top ports
module fbsi_props (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [2:0] net_state,
    input wire logic       bus_off,
    input wire logic       init_failed,
    input wire logic       fault_active,
    input wire logic       error_frames,
    input wire logic       guard_event,
    input wire logic       run_lamp,
    input wire logic       err_lamp,
    input wire logic       address_unset_alarm,
    input wire logic       join_enable,
    input wire logic [6:0] active_address,
    input wire logic [3:0] active_rate,
    input wire logic       auto_rate
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // any pending error cause
    wire any_err = bus_off | init_failed | fault_active | error_frames
                   | guard_event;
    // the sampled reset in each antecedent keeps the edge of release,
    // where the lamps are still cleared, out of the lamp checks
    a_scan_alternate: assert property (
        !sys_rst && net_state == 3'h4 |=> run_lamp != err_lamp)
        else $error("lamps not alternating in scan");
    a_run_oper_on: assert property (
        !sys_rst && net_state == 3'h2 |=> run_lamp)
        else $error("run lamp dark while operational");
    a_err_busoff_on: assert property (
        !sys_rst && bus_off && net_state != 3'h4 |=> err_lamp)
        else $error("error lamp dark while bus-off");
    a_err_clean_off: assert property (
        !sys_rst && !any_err && net_state != 3'h4 |=> !err_lamp)
        else $error("error lamp lit with no error");
    a_alarm_addr_zero: assert property (
        address_unset_alarm |-> active_address == 7'h00 && !join_enable)
        else $error("alarm with address set");
    a_join_addr_set: assert property (
        join_enable |-> active_address != 7'h00)
        else $error("joined with address zero");
    a_settings_frozen: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2) |->
        $stable(active_address) && $stable(active_rate)
        && $stable(auto_rate) && $stable(address_unset_alarm)
        && $stable(join_enable))
        else $error("settings changed in operation");
    a_setting_range: assert property (
        active_address <= 7'h7e && active_rate <= 4'h8
        && (!auto_rate || active_rate == 4'h0))
        else $error("setting out of range");
endmodule // fbsi_props
`default_nettype wire

// ===== tb/fbsi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fbsi_top_tb;
    logic       sys_clk  = 1'b0;
    logic       sys_rst  = 1'b1;
    logic [7:0] cmd      = 8'h00;   // state and events for the master
    logic [6:0] addr_set = 7'h00;
    logic [3:0] rate_set = 4'h0;
    logic [2:0] net_state;
    logic [4:0] ev;                 // bus_off down to guard_event
    logic       run_lamp, err_lamp, alarm, join_en, auto_rate;
    logic [6:0] act_addr;
    logic [3:0] act_rate;
    logic [7:0] got, exp;
    int         fail_count = 0;
    int         n_checks   = 0;
    // rows: state, events, expected run/err, care run/err
    logic [11:0] rows [12] = '{12'h40b, 12'h20a, 12'h60a, 12'h505,
        12'h485, 12'h445, 12'h425, 12'h415, 12'h9f7, 12'h003,
        12'he03, 12'h40b};
    always #5 sys_clk = ~sys_clk;
    fbsi_master_model i_master (.sys_clk(sys_clk), .cmd(cmd),
        .net_state(net_state), .events(ev));
    fbsi_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .net_state(net_state), .bus_off(ev[4]), .init_failed(ev[3]),
        .fault_active(ev[2]), .error_frames(ev[1]), .guard_event(ev[0]),
        .node_address_setting(addr_set), .bit_rate_setting(rate_set),
        .run_lamp(run_lamp), .err_lamp(err_lamp),
        .address_unset_alarm(alarm), .join_enable(join_en),
        .active_address(act_addr), .active_rate(act_rate),
        .auto_rate(auto_rate));
    // one compare for every result, x never matches
    task automatic check_val(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // settings are only taken at the first edge after release
    task automatic do_reset(input logic [6:0] a, input logic [3:0] r);
        @(posedge sys_clk);
        sys_rst  <= 1'b1;
        addr_set <= a;
        rate_set <= r;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        do_reset(7'h00, 4'h0);
        check_val({5'h00, alarm, join_en, auto_rate}, 8'h05);
        $display("unset address test done");
        // slow flash timers stay in their first lit slot here
        foreach (rows[i]) begin
            @(posedge sys_clk);
            cmd <= rows[i][11:4];
            repeat (3) @(posedge sys_clk);
            #1;
            got = {6'h00, {run_lamp, err_lamp} & rows[i][1:0]};
            exp = {6'h00, rows[i][3:2] & rows[i][1:0]};
            check_val(got, exp);
        end
        $display("lamp table test done");
        @(posedge sys_clk);
        addr_set <= 7'h7e;
        rate_set <= 4'h8;
        repeat (3) @(posedge sys_clk);
        #1;
        check_val({1'b0, act_addr}, 8'h00);
        got = {act_rate, 1'b0, alarm, join_en, auto_rate};
        check_val(got, 8'h05);
        do_reset(7'h7e, 4'h8);
        check_val({1'b0, act_addr}, 8'h7e);
        got = {act_rate, 1'b0, alarm, join_en, auto_rate};
        check_val(got, 8'h82);
        $display("power cycle test done");
        // settings above the legal range come out clamped
        do_reset(7'h7f, 4'hf);
        check_val({1'b0, act_addr}, 8'h7e);
        got = {act_rate, 1'b0, alarm, join_en, auto_rate};
        check_val(got, 8'h82);
        $display("clamp test done");
        complete_run();
    end
endmodule // fbsi_top_tb
bind fbsi_top fbsi_props i_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .net_state(net_state), .bus_off(bus_off), .init_failed(init_failed),
    .fault_active(fault_active), .error_frames(error_frames),
    .guard_event(guard_event), .run_lamp(run_lamp), .err_lamp(err_lamp),
    .address_unset_alarm(address_unset_alarm), .join_enable(join_enable),
    .active_address(active_address), .active_rate(active_rate),
    .auto_rate(auto_rate));
`default_nettype wire
